// File: verilog/flash_seq_pkg.sv
// Purpose: Shared constants for the flash sequencing controller.
// Assumes: 40 MHz system clock; device array reached over a byte-wide memory port.
// Notes: Times are held in microseconds and turned into cycle counts here.
package flash_seq_pkg;

	// Clock and timing
	localparam int CLK_MHZ = 40;
	localparam int SETUP_DELAY_US = 10;
	localparam int MASS_ERASE_TIME_US = 4000;
	localparam int LONG_HOLD_DELAY_US = 100;
	localparam int HOLD_DELAY_US = 5;
	localparam int PROGRAM_SETUP_DELAY_US = 5;
	localparam int BYTE_PROGRAM_TIME_US = 30;
	localparam int RECOVERY_DELAY_US = 1;
	localparam int NVS_CYC = SETUP_DELAY_US * CLK_MHZ;
	localparam int MERASE_CYC = MASS_ERASE_TIME_US * CLK_MHZ;
	localparam int NVHL_CYC = LONG_HOLD_DELAY_US * CLK_MHZ;
	localparam int NVH_CYC = HOLD_DELAY_US * CLK_MHZ;
	localparam int PGS_CYC = PROGRAM_SETUP_DELAY_US * CLK_MHZ;
	localparam int PROG_CYC = BYTE_PROGRAM_TIME_US * CLK_MHZ;
	localparam int RCV_CYC = RECOVERY_DELAY_US * CLK_MHZ;
	localparam int TIMER_W = 18;

	// Device memory map
	localparam logic [15:0] PROT_ADDR = 16'hFF7E;
	localparam logic [15:0] TRIM_HI_ADDR = 16'hFF80;
	localparam logic [15:0] TRIM_LO_ADDR = 16'hFF81;
	localparam logic [15:0] WATCHDOG_ADDR = 16'hFFFF;
	localparam logic [15:0] ARRAY_BASE = 16'hC000;
	localparam logic [7:0] ERASED = 8'hFF;
	localparam logic [7:0] PROT_ALL = 8'h00;
	localparam logic [7:0] PROT_VEC = 8'hFE;
	localparam logic [1:0] PROT_TOP = 2'h3;
	localparam int ROW_BYTES = 32;

	// Own register map (byte offsets)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_LEN = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RESULT = 8'h14;

	// Control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_MON = 3;
	localparam logic [1:0] OP_MASS = 2'h0;
	localparam logic [1:0] OP_ROW = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;

	// Status fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR_PROT = 2;
	localparam int ST_ERR_BUSY = 3;
	localparam int ST_SKIPPED = 4;

	// Reset values
	localparam logic [15:0] ADDR_RST = ARRAY_BASE;
	localparam logic [5:0] LEN_RST = 6'h20;

endpackage

// File: verilog/wait_timer.sv
// Purpose: Down-counter that times the minimum waits of a flash sequence.
// Assumes: load is a one-cycle pulse; count is at least one.
// Notes: expired is high once count cycles have passed after the load.
`timescale 1ns/1ps
module wait_timer #(
	parameter int W = 18
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Control
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic expired
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} tmr_t;

	tmr_t r;
	tmr_t n;

	always_comb begin
		n = r;
		if (load) begin
			n.cnt = count;
		end else if (r.cnt != '0) begin
			n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign expired = (r.cnt == '0);

endmodule

// File: verilog/protect_check.sv
// Purpose: Decides from the protect byte whether a row program or a mass erase is permitted.
// Assumes: prot_byte is the value just read from the device.
// Notes: Purely combinational.
`timescale 1ns/1ps
module protect_check (
	// Inputs
	input wire logic [7:0] prot_byte,
	input wire logic [15:0] row_addr,
	// Results
	output logic [15:0] start_addr,
	output logic row_locked,
	output logic mass_ok
);

	function automatic logic [15:0] start_of(input logic [7:0] b);
		start_of = {flash_seq_pkg::PROT_TOP, b, 6'h00};
	endfunction

	logic fixed;

	always_comb begin
		start_addr = start_of(prot_byte);
		fixed = (prot_byte != flash_seq_pkg::ERASED) && (prot_byte != flash_seq_pkg::PROT_VEC);
		row_locked = (prot_byte == flash_seq_pkg::PROT_ALL)
			|| ((prot_byte != flash_seq_pkg::ERASED) && (row_addr >= start_addr))
			|| (fixed && (row_addr[15:5] == flash_seq_pkg::PROT_ADDR[15:5]));
		mass_ok = (prot_byte == flash_seq_pkg::ERASED);
	end

endmodule

// File: verilog/flash_host_ctrl.sv
// Purpose: APB-steered controller that runs mass-erase, row-program and read
//   sequences on the flash array through its control pins and memory port.
// Assumes: mem_rdata is valid in the cycle after mem_rd is high.
// Notes: Minimum waits are counted in sys_clk cycles at 40 MHz.
`timescale 1ns/1ps
module flash_host_ctrl #(
	parameter int unsigned MERASE_CYC = flash_seq_pkg::MERASE_CYC,
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash control pins
	output logic erase_select,
	output logic mass_select,
	output logic program_select,
	output logic high_voltage_enable,
	// Flash memory port
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_wr,
	output logic mem_rd,
	input wire logic [7:0] mem_rdata
);

	localparam int TW = flash_seq_pkg::TIMER_W;

	typedef enum logic [4:0] {
		S_IDLE, S_SCAN_RD, S_SCAN_W, S_SCAN_CHK, S_SEL, S_PROT_RD, S_PROT_W,
		S_PROT_CHK, S_NVS, S_HV_WAIT, S_PICK, S_PROG_W, S_HOLD, S_RCV,
		S_RD_ISSUE, S_RD_W, S_RD_CHK
	} state_t;

	typedef struct packed {
		state_t st;
		logic [1:0] op;
		logic mon;
		logic [15:0] addr;
		logic [5:0] len;
		logic [4:0] wptr;
		logic [4:0] idx;
		logic [5:0] left;
		logic [31:0] need;
		logic erase_sel;
		logic mass_sel;
		logic prog_sel;
		logic hv_en;
		logic [15:0] maddr;
		logic [7:0] mwdata;
		logic mwr;
		logic mrd;
		logic busy;
		logic done;
		logic err_prot;
		logic err_busy;
		logic skipped;
		logic [7:0] prot;
		logic [7:0] rdata;
		logic [31:0] prdata;
		logic tload;
		logic [TW-1:0] tval;
	} ctl_t;

	ctl_t r;
	ctl_t n;

	logic [7:0] row_buf [flash_seq_pkg::ROW_BYTES];
	logic t_exp;
	logic t_done;
	logic row_locked;
	logic mass_ok;
	logic [15:0] row_base;
	logic wr_acc;
	logic rd_setup;
	logic buf_we;
	logic [5:0] room;

	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] off);
		hit = (a == AW'(off));
	endfunction

	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = hit(a, flash_seq_pkg::REG_CTRL) || hit(a, flash_seq_pkg::REG_ADDR)
			|| hit(a, flash_seq_pkg::REG_LEN) || hit(a, flash_seq_pkg::REG_DATA)
			|| hit(a, flash_seq_pkg::REG_STATUS) || hit(a, flash_seq_pkg::REG_RESULT);
	endfunction

	wait_timer #(.W(TW)) u_timer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(r.tload),
		.count(r.tval),
		.expired(t_exp)
	);

	protect_check u_prot (
		.prot_byte(mem_rdata),
		.row_addr(row_base),
		.start_addr(),
		.row_locked(row_locked),
		.mass_ok(mass_ok)
	);

	assign row_base = {r.addr[15:5], 5'h00};
	assign t_done = t_exp && !r.tload;
	assign wr_acc = psel && penable && pwrite && mapped(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign buf_we = wr_acc && hit(paddr, flash_seq_pkg::REG_DATA) && !r.busy;
	assign room = 6'(flash_seq_pkg::ROW_BYTES) - {1'b0, r.addr[4:0]};

	always_comb begin
		n = r;
		n.tload = 1'b0;
		n.mwr = 1'b0;
		n.mrd = 1'b0;

		// Register reads are captured in the setup phase
		if (rd_setup) begin
			n.prdata = '0;
			if (hit(paddr, flash_seq_pkg::REG_CTRL)) begin
				n.prdata = {28'h0, r.mon, r.op, 1'b0};
			end else if (hit(paddr, flash_seq_pkg::REG_ADDR)) begin
				n.prdata = {16'h0, r.addr};
			end else if (hit(paddr, flash_seq_pkg::REG_LEN)) begin
				n.prdata = {26'h0, r.len};
			end else if (hit(paddr, flash_seq_pkg::REG_STATUS)) begin
				n.prdata = {27'h0, r.skipped, r.err_busy, r.err_prot, r.done, r.busy};
			end else if (hit(paddr, flash_seq_pkg::REG_RESULT)) begin
				n.prdata = {16'h0, r.prot, r.rdata};
			end
		end

		// Register writes; status bits other than busy clear on a one, hardware sets below win
		if (wr_acc) begin
			if (hit(paddr, flash_seq_pkg::REG_STATUS)) begin
				n.done = r.done && !pwdata[flash_seq_pkg::ST_DONE];
				n.err_prot = r.err_prot && !pwdata[flash_seq_pkg::ST_ERR_PROT];
				n.err_busy = r.err_busy && !pwdata[flash_seq_pkg::ST_ERR_BUSY];
				n.skipped = r.skipped && !pwdata[flash_seq_pkg::ST_SKIPPED];
			end else if (r.busy && !hit(paddr, flash_seq_pkg::REG_RESULT)) begin
				n.err_busy = 1'b1;
			end else if (hit(paddr, flash_seq_pkg::REG_ADDR)) begin
				n.addr = pwdata[15:0];
				n.wptr = pwdata[4:0];
			end else if (hit(paddr, flash_seq_pkg::REG_LEN)) begin
				n.len = pwdata[5:0];
			end else if (hit(paddr, flash_seq_pkg::REG_DATA)) begin
				n.wptr = r.wptr + 5'h01;
			end else if (hit(paddr, flash_seq_pkg::REG_CTRL)) begin
				n.op = pwdata[flash_seq_pkg::CTRL_OP_LSB +: 2];
				n.mon = pwdata[flash_seq_pkg::CTRL_MON];
				if (pwdata[flash_seq_pkg::CTRL_START]) begin
					n.busy = 1'b1;
					n.need = '0;
					n.idx = r.addr[4:0];
					n.left = (r.len > room) ? room : r.len;
					unique case (n.op)
						flash_seq_pkg::OP_MASS: n.st = S_SEL;
						flash_seq_pkg::OP_ROW: n.st = (r.len == '0) ? S_RCV : S_SCAN_RD;
						default: n.st = S_RD_ISSUE;
					endcase
				end
			end
		end

		// Sequencer, steps strictly in order
		unique case (r.st)
			S_IDLE: begin
			end
			S_SCAN_RD: begin
				n.maddr = {r.addr[15:5], r.idx};
				n.mrd = 1'b1;
				n.st = S_SCAN_W;
			end
			S_SCAN_W: n.st = S_SCAN_CHK;
			S_SCAN_CHK: begin
				if (row_buf[r.idx] != flash_seq_pkg::ERASED) begin
					if (mem_rdata == flash_seq_pkg::ERASED
						&& r.maddr != flash_seq_pkg::WATCHDOG_ADDR) begin
						n.need[r.idx] = 1'b1;
					end else begin
						n.skipped = 1'b1;
					end
				end
				n.idx = r.idx + 5'h01;
				n.left = r.left - 6'h01;
				if (r.left == 6'h01) begin
					n.idx = r.addr[4:0];
					if (n.need == '0) begin
						n.tval = TW'(flash_seq_pkg::RCV_CYC);
						n.tload = 1'b1;
						n.st = S_RCV;
					end else begin
						n.st = S_SEL;
					end
				end else begin
					n.st = S_SCAN_RD;
				end
			end
			S_SEL: begin
				if (r.op == flash_seq_pkg::OP_MASS) begin
					n.erase_sel = 1'b1;
					n.mass_sel = 1'b1;
				end else begin
					n.prog_sel = 1'b1;
				end
				n.st = S_PROT_RD;
			end
			S_PROT_RD: begin
				n.maddr = flash_seq_pkg::PROT_ADDR;
				n.mrd = 1'b1;
				n.st = S_PROT_W;
			end
			S_PROT_W: n.st = S_PROT_CHK;
			S_PROT_CHK: begin
				n.prot = mem_rdata;
				if ((r.op == flash_seq_pkg::OP_MASS) ? !mass_ok : row_locked) begin
					n.err_prot = 1'b1;
					n.erase_sel = 1'b0;
					n.mass_sel = 1'b0;
					n.prog_sel = 1'b0;
					n.tval = TW'(flash_seq_pkg::RCV_CYC);
					n.tload = 1'b1;
					n.st = S_RCV;
				end else begin
					if (r.op == flash_seq_pkg::OP_MASS) begin
						n.maddr = r.mon ? flash_seq_pkg::PROT_ADDR : r.addr;
					end else begin
						n.maddr = {r.addr[15:5], r.idx};
					end
					n.mwdata = flash_seq_pkg::ERASED;
					n.mwr = 1'b1;
					n.tval = TW'(flash_seq_pkg::NVS_CYC);
					n.tload = 1'b1;
					n.st = S_NVS;
				end
			end
			S_NVS: begin
				if (t_done) begin
					n.hv_en = 1'b1;
					n.tval = (r.op == flash_seq_pkg::OP_MASS) ? TW'(MERASE_CYC)
						: TW'(flash_seq_pkg::PGS_CYC);
					n.tload = 1'b1;
					n.st = S_HV_WAIT;
				end
			end
			S_HV_WAIT: begin
				if (t_done) begin
					if (r.op == flash_seq_pkg::OP_MASS) begin
						n.erase_sel = 1'b0;
						n.mass_sel = 1'b0;
						n.tval = TW'(flash_seq_pkg::NVHL_CYC);
						n.tload = 1'b1;
						n.st = S_HOLD;
					end else begin
						n.st = S_PICK;
					end
				end
			end
			S_PICK: begin
				if (r.need[r.idx]) begin
					n.maddr = {r.addr[15:5], r.idx};
					n.mwdata = row_buf[r.idx];
					n.mwr = 1'b1;
					n.need[r.idx] = 1'b0;
					n.tval = TW'(flash_seq_pkg::PROG_CYC);
					n.tload = 1'b1;
					n.st = S_PROG_W;
				end else if (r.need == '0) begin
					n.prog_sel = 1'b0;
					n.tval = TW'(flash_seq_pkg::NVH_CYC);
					n.tload = 1'b1;
					n.st = S_HOLD;
				end else begin
					n.idx = r.idx + 5'h01;
				end
			end
			S_PROG_W: begin
				if (t_done) begin
					n.st = S_PICK;
				end
			end
			S_HOLD: begin
				if (t_done) begin
					n.hv_en = 1'b0;
					n.tval = TW'(flash_seq_pkg::RCV_CYC);
					n.tload = 1'b1;
					n.st = S_RCV;
				end
			end
			S_RCV: begin
				if (t_done) begin
					n.busy = 1'b0;
					n.done = 1'b1;
					n.st = S_IDLE;
				end
			end
			S_RD_ISSUE: begin
				n.maddr = r.addr;
				n.mrd = 1'b1;
				n.st = S_RD_W;
			end
			S_RD_W: n.st = S_RD_CHK;
			S_RD_CHK: begin
				n.rdata = mem_rdata;
				n.busy = 1'b0;
				n.done = 1'b1;
				n.st = S_IDLE;
			end
			default: n.st = S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			r.st <= S_IDLE;
			r.addr <= flash_seq_pkg::ADDR_RST;
			r.len <= flash_seq_pkg::LEN_RST;
			r.wptr <= flash_seq_pkg::ADDR_RST[4:0];
			r.mwdata <= flash_seq_pkg::ERASED;
		end else begin
			r <= n;
		end
	end

	// Row data staged by software, no reset needed
	always_ff @(posedge sys_clk) begin
		if (buf_we) begin
			row_buf[r.wptr] <= pwdata[7:0];
		end
	end

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign erase_select = r.erase_sel;
	assign mass_select = r.mass_sel;
	assign program_select = r.prog_sel;
	assign high_voltage_enable = r.hv_en;
	assign mem_addr = r.maddr;
	assign mem_wdata = r.mwdata;
	assign mem_wr = r.mwr;
	assign mem_rd = r.mrd;

endmodule

// File: sim/flash_host_ctrl_asserts.sv
// Purpose: Port checks for the flash sequencing controller.
// Assumes: Selects, high voltage and memory strobes are registered.
// Notes: Counters measure the waits between sequence steps.
`timescale 1ns/1ps
module flash_host_ctrl_asserts #(
	parameter int unsigned MERASE_CYC = flash_seq_pkg::MERASE_CYC,
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Flash pins and port
	input wire logic erase_select,
	input wire logic mass_select,
	input wire logic program_select,
	input wire logic high_voltage_enable,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [7:0] mem_rdata
);
	localparam int NVS_M = flash_seq_pkg::NVS_CYC - 1;
	localparam int PGS_M = flash_seq_pkg::PGS_CYC - 1;
	localparam int PROG_M = flash_seq_pkg::PROG_CYC - 1;
	localparam int NVH_M = flash_seq_pkg::NVH_CYC - 1;
	localparam int NVHL_M = flash_seq_pkg::NVHL_CYC - 1;
	logic [19:0] wr_cnt_r, hv_cnt_r, off_cnt_r;
	logic [15:0] tgt_r;
	logic [7:0] prot_r;
	logic rd_d_r, seen_r, mass_r, wr_hv_r;
	wire logic sel = erase_select || program_select;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_cnt_r <= 20'h00000;
			hv_cnt_r <= 20'h00000;
			off_cnt_r <= 20'h00000;
			tgt_r <= 16'h0000;
			prot_r <= 8'h00;
			rd_d_r <= 1'b0;
			seen_r <= 1'b0;
			mass_r <= 1'b0;
			wr_hv_r <= 1'b0;
		end else begin
			wr_cnt_r <= mem_wr ? 20'h00000 : wr_cnt_r + 20'h00001;
			hv_cnt_r <= high_voltage_enable ? hv_cnt_r + 20'h00001 : 20'h00000;
			off_cnt_r <= sel ? 20'h00000 : off_cnt_r + 20'h00001;
			rd_d_r <= mem_rd && mem_addr == flash_seq_pkg::PROT_ADDR;
			seen_r <= sel && (seen_r || rd_d_r);
			wr_hv_r <= high_voltage_enable && (wr_hv_r || mem_wr);
			if (rd_d_r) prot_r <= mem_rdata;
			if (mem_wr) tgt_r <= mem_addr;
			if (sel) mass_r <= mass_select;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence hv_held;
		high_voltage_enable [*8];
	endsequence
	sequence port_quiet;
		(!mem_rd && !mem_wr) [*8];
	endsequence
	sel_interlock_a: assert property (!(erase_select && program_select))
		else $error("erase and program select both high");
	hv_after_read_a: assert property ($rose(high_voltage_enable) |-> seen_r)
		else $error("high voltage without select and protect read");
	hv_setup_a: assert property ($rose(high_voltage_enable) |-> wr_cnt_r >= NVS_M)
		else $error("high voltage too soon after dummy write");
	mass_guard_a: assert property ($rose(high_voltage_enable) && mass_select |->
		prot_r == flash_seq_pkg::ERASED)
		else $error("mass erase with protection set");
	row_guard_a: assert property ($rose(high_voltage_enable) && program_select |->
		prot_r == 8'hFF || tgt_r < {2'b11, prot_r, 6'h00})
		else $error("high voltage on protected row");
	mass_hold_a: assert property ($fell(mass_select) && high_voltage_enable |->
		hv_cnt_r >= MERASE_CYC - 1 && !erase_select)
		else $error("mass erase hold too short");
	hv_off_a: assert property ($fell(high_voltage_enable) |->
		off_cnt_r >= (mass_r ? NVHL_M : NVH_M))
		else $error("high voltage cleared too soon");
	byte_space_a: assert property (mem_wr && high_voltage_enable |-> program_select &&
		hv_cnt_r >= PGS_M && (!wr_hv_r || wr_cnt_r >= PROG_M))
		else $error("byte write spacing too short");
	no_watchdog_a: assert property (mem_wr && high_voltage_enable |->
		mem_addr != flash_seq_pkg::WATCHDOG_ADDR)
		else $error("watchdog address written under high voltage");
	row_align_a: assert property (mem_wr && high_voltage_enable |->
		mem_addr[15:5] == tgt_r[15:5])
		else $error("programmed byte outside the row");
	desel_hold_a: assert property ($fell(program_select) && high_voltage_enable |-> hv_held)
		else $error("high voltage dropped with program select");
	recover_a: assert property ($fell(high_voltage_enable) |-> port_quiet)
		else $error("array access during recovery");
endmodule
bind flash_host_ctrl flash_host_ctrl_asserts #(.MERASE_CYC(MERASE_CYC), .AW(AW))
	u_flash_host_ctrl_asserts (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .erase_select, .mass_select, .program_select,
	.high_voltage_enable, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);

// File: sim/flash_dev_model.sv
// Purpose: Behavioural flash array with control pins and block protection.
// Assumes: Read data is returned in the cycle after mem_rd.
// Notes: No test high voltage, so the protect byte never changes by programming.
`timescale 1ns/1ps
module flash_dev_model (
	// Clock
	input wire logic sys_clk,
	// Control pins
	input wire logic erase_select,
	input wire logic mass_select,
	input wire logic program_select,
	input wire logic high_voltage_enable,
	// Memory port
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [15:0] wr_addr_r = 16'h0000;
	logic hv_ok_r = 1'b0;
	logic hv_d_r = 1'b0;
	logic hv_mass_r = 1'b0;
	logic prot_seen_r = 1'b0;
	logic [7:0] oscillator_trim_reg = 8'h00;
	wire logic [7:0] prot = mem[16'hFF7E];
	wire logic [15:0] start = {2'b11, prot, 6'h00};
	function automatic logic locked(input logic [15:0] a);
		return prot != 8'hFF && a >= start;
	endfunction
	// Startup copy of the high-supply trim, skipped when erased
	task automatic monitor_start();
		if (mem[16'hFF80] != 8'hFF) oscillator_trim_reg = mem[16'hFF80];
	endtask
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
	end
	always @(posedge sys_clk) begin
		hv_d_r <= high_voltage_enable;
		// Out-of-order high voltage is ignored
		prot_seen_r <= (erase_select || program_select) &&
			(prot_seen_r || (mem_rd && mem_addr == 16'hFF7E));
		// Stale read data is inverted, never held
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
		if (mem_wr) wr_addr_r <= mem_addr;
		if (high_voltage_enable && !hv_d_r) begin
			hv_ok_r <= (erase_select ^ program_select) && prot_seen_r && !locked(wr_addr_r) &&
				(!mass_select || prot == 8'hFF);
			hv_mass_r <= mass_select;
		end
		if (program_select && high_voltage_enable && hv_ok_r && mem_wr && !locked(mem_addr) &&
			mem_addr != 16'hFF7E) mem[mem_addr] <= mem[mem_addr] & mem_wdata;
		if (hv_d_r && !high_voltage_enable && hv_ok_r && hv_mass_r) begin
			for (int a = 16'hC000; a < 65536; a++) mem[a] <= 8'hFF;
		end
	end
endmodule

// File: sim/tb.sv
// Purpose: Self-checking bench for the flash sequencing controller.
// Assumes: Device array modelled by flash_dev_model.
// Notes: Mass erase hold shortened through MERASE_CYC.
`timescale 1ns/1ps
module tb;
	localparam int unsigned MER = 50;
	localparam logic [7:0] A_ADDR = flash_seq_pkg::REG_ADDR;
	localparam logic [7:0] A_LEN = flash_seq_pkg::REG_LEN;
	localparam logic [7:0] A_ST = flash_seq_pkg::REG_STATUS;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd_q;
	logic pready, pslverr, rd_err, mem_wr, mem_rd;
	logic erase_select, mass_select, program_select, high_voltage_enable;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [7:0] pv [4] = '{8'h00, 8'h01, 8'h01, 8'hFD};
	logic [15:0] pa [4] = '{16'hC000, 16'hC030, 16'hC040, 16'hFF60};
	logic [3:0] pe = 4'b1101;
	flash_host_ctrl #(.MERASE_CYC(MER)) u_flash_host_ctrl (.sys_clk, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .erase_select, .mass_select,
		.program_select, .high_voltage_enable, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
		.mem_rdata);
	flash_dev_model u_flash_dev_model (.sys_clk, .erase_select, .mass_select, .program_select,
		.high_voltage_enable, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);
	always #12.5 sys_clk = ~sys_clk;
	task automatic complete_run();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd_q = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic run(input logic [1:0] op, input logic mon, input logic busy_wr);
		apb(1'b1, A_ST, 32'h0000001E);
		apb(1'b1, flash_seq_pkg::REG_CTRL, {28'h0000000, mon, op, 1'b1});
		if (busy_wr) apb(1'b1, A_ADDR, 32'h0000FFFF);
		do apb(1'b0, A_ST, 32'h00000000); while (rd_q[1] !== 1'b1);
	endtask
	task automatic rd_flash(input logic [15:0] a);
		apb(1'b1, A_ADDR, {16'h0000, a});
		run(flash_seq_pkg::OP_READ, 1'b0, 1'b0);
		apb(1'b0, flash_seq_pkg::REG_RESULT, 32'h00000000);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, A_ADDR, 32'h00000000);
		chk("addr reset", rd_q, 32'h0000C000);
		apb(1'b0, 8'h18, 32'h00000000);
		chk("unmapped error", {31'h0, rd_err}, 32'h00000001);
		// Row with a byte already programmed and a write while busy
		u_flash_dev_model.mem[16'hC021] = 8'h00;
		apb(1'b1, A_ADDR, 32'h0000C020);
		apb(1'b1, A_LEN, 32'h00000004);
		for (int i = 0; i < 4; i++) apb(1'b1, flash_seq_pkg::REG_DATA, 32'h11 * (i + 1));
		run(flash_seq_pkg::OP_ROW, 1'b0, 1'b1);
		chk("row status", rd_q, 32'h0000001A);
		apb(1'b0, A_ADDR, 32'h00000000);
		chk("addr kept", rd_q, 32'h0000C020);
		for (int i = 0; i < 5; i++) begin
			rd_flash(16'hC020 + 16'(i));
			chk("row byte", {24'h0, rd_q[7:0]}, i == 1 ? 32'h0 : i == 4 ? 32'hFF : 32'h11 * (i + 1));
		end
		// Targets on both sides of the protect start address
		for (int i = 0; i < 4; i++) begin
			u_flash_dev_model.mem[16'hFF7E] = pv[i];
			apb(1'b1, A_ADDR, {16'h0000, pa[i]});
			apb(1'b1, A_LEN, 32'h00000001);
			apb(1'b1, flash_seq_pkg::REG_DATA, 32'h000000A5);
			run(flash_seq_pkg::OP_ROW, 1'b0, 1'b0);
			chk("protect error", {31'h0, rd_q[2]}, {31'h0, pe[i]});
			chk("target byte", {24'h0, u_flash_dev_model.mem[pa[i]]}, pe[i] ? 32'hFF : 32'hA5);
		end
		// Mass erase refused, then run with the monitor dummy target
		u_flash_dev_model.mem[16'hFF80] = 8'h5C;
		u_flash_dev_model.mem[16'hFF81] = 8'h3A;
		u_flash_dev_model.monitor_start();
		chk("trim copy", {24'h0, u_flash_dev_model.oscillator_trim_reg}, 32'h0000005C);
		for (int j = 0; j < 2; j++) begin
			u_flash_dev_model.mem[16'hFF7E] = j ? 8'hFF : 8'hFE;
			run(flash_seq_pkg::OP_MASS, j[0], 1'b0);
			chk("mass error", {31'h0, rd_q[2]}, {31'h0, ~j[0]});
			chk("trim high", {24'h0, u_flash_dev_model.mem[16'hFF80]}, j ? 32'hFF : 32'h5C);
			chk("trim low", {24'h0, u_flash_dev_model.mem[16'hFF81]}, j ? 32'hFF : 32'h3A);
		end
		chk("dummy target", {16'h0, u_flash_dev_model.wr_addr_r}, 32'h0000FF7E);
		u_flash_dev_model.monitor_start();
		chk("trim kept", {24'h0, u_flash_dev_model.oscillator_trim_reg}, 32'h0000005C);
		rd_flash(16'hC020);
		chk("erased byte", {24'h0, rd_q[7:0]}, 32'h000000FF);
		complete_run();
	end
endmodule
